// ### hdl/lcd_parallel_host_port.sv
// host side controller that drives the display controller's parallel port
// assumes one 50 MHz clock; bus turnaround relies on the device releasing data when not read
// bus_in comes straight from the pins and is synchronised before any logic reads it
//
// Overview of operation
// - select is driven low for every access, high otherwise.
// - register/data select is driven from the request on every access.
// - 8080 mode: write strobe pulsed low to write.
// - 8080 mode: read strobe driven low to read.
// - 6800 mode: direction pin shares read strobe, high read, low write.
// - host drives the dedicated reset input of the display controller.
`timescale 1ns/1ns
module lcd_parallel_host_port #(
    // phase lengths in clock cycles; each must be one or more
    parameter int RESET_CYCLES   = lcd_host_pkg::RESET_CYC,
    parameter int SETUP_CYCLES   = lcd_host_pkg::SETUP_CYC,
    parameter int ACTIVE_CYCLES  = lcd_host_pkg::ACTIVE_CYC,
    parameter int HOLD_CYCLES    = lcd_host_pkg::HOLD_CYC,
    parameter int RECOVER_CYCLES = lcd_host_pkg::PW_LOW_CYC
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // configuration: mode_6800 sampled when a request is taken, colour_262k copied every cycle, soft_reset seen in idle
    input  wire logic                          mode_6800,
    input  wire logic                          colour_262k,
    input  wire logic                          soft_reset,
    // request side
    input  wire logic                          req_valid,
    input  wire lcd_host_pkg::request_t        req,
    output logic                               req_ready,
    output logic                               rd_valid,
    output logic [lcd_host_pkg::DATA_W-1:0]    rd_data,
    // display pins
    output lcd_host_pkg::pins_t                pins,
    input  wire logic [lcd_host_pkg::DATA_W-1:0] bus_in
);
    typedef logic [lcd_host_pkg::CNT_W-1:0] count_t;

    // last count of each phase, cut to the counter width on purpose
    localparam count_t RESET_LAST   = count_t'(RESET_CYCLES - 1);
    localparam count_t SETUP_LAST   = count_t'(SETUP_CYCLES - 1);
    localparam count_t ACTIVE_LAST  = count_t'(ACTIVE_CYCLES - 1);
    localparam count_t HOLD_LAST    = count_t'(HOLD_CYCLES - 1);
    localparam count_t RECOVER_LAST = count_t'(RECOVER_CYCLES - 1);

    // reset image: display held in reset, select and strobes idle high, bus released
    localparam lcd_host_pkg::state_t RESET_IMAGE = '{
        phase:     lcd_host_pkg::ST_RESET,
        cnt:       '0,
        req:       '0,
        mode_6800: 1'b0,
        pins:      '{
            host_select_n:        1'b1,
            register_data_select: 1'b0,
            wr_strobe:            1'b1,
            rd_strobe:            1'b1,
            reset_n:              1'b0,
            colour_depth_select:  1'b0,
            bus_out:              '0,
            bus_oe:               1'b0
        },
        ready:     1'b0,
        rvalid:    1'b0,
        rdata:     '0,
        sync1:     '0,
        sync2:     '0
    };

    lcd_host_pkg::state_t cur_ff;
    lcd_host_pkg::state_t nxt_ff;
    count_t               last_cnt;
    logic                 cnt_done;

    always_comb begin
        // one terminal count per phase keeps the counters alike
        case (cur_ff.phase)
            lcd_host_pkg::ST_RESET:   last_cnt = RESET_LAST;
            lcd_host_pkg::ST_SETUP:   last_cnt = SETUP_LAST;
            lcd_host_pkg::ST_ACTIVE:  last_cnt = ACTIVE_LAST;
            lcd_host_pkg::ST_HOLD:    last_cnt = HOLD_LAST;
            lcd_host_pkg::ST_RECOVER: last_cnt = RECOVER_LAST;
            default:                  last_cnt = '0;
        endcase
        cnt_done = (cur_ff.cnt >= last_cnt);

        nxt_ff = cur_ff;
        nxt_ff.rvalid = 1'b0;
        nxt_ff.sync1 = bus_in;
        nxt_ff.sync2 = cur_ff.sync1;
        nxt_ff.pins.colour_depth_select = colour_262k;
        case (cur_ff.phase)
            lcd_host_pkg::ST_RESET: begin
                nxt_ff.pins.reset_n = 1'b0;
                // ready stays low until the display has left reset
                if (cnt_done) begin
                    nxt_ff.pins.reset_n = 1'b1;
                    nxt_ff.phase = lcd_host_pkg::ST_IDLE;
                    nxt_ff.ready = 1'b1;
                    nxt_ff.cnt = '0;
                end else begin
                    nxt_ff.cnt = cur_ff.cnt + 16'h0001;
                end
            end

            lcd_host_pkg::ST_IDLE: begin
                nxt_ff.pins.host_select_n = 1'b1;
                nxt_ff.pins.bus_oe = 1'b0;
                nxt_ff.pins.wr_strobe = ~mode_6800;
                nxt_ff.pins.rd_strobe = 1'b1;
                // a soft reset is only taken in idle so no access is cut short
                if (soft_reset) begin
                    nxt_ff.phase = lcd_host_pkg::ST_RESET;
                    nxt_ff.ready = 1'b0;
                    nxt_ff.cnt = '0;
                end else if (req_valid) begin
                    nxt_ff.req = req;
                    nxt_ff.mode_6800 = mode_6800;
                    nxt_ff.ready = 1'b0;
                    nxt_ff.phase = lcd_host_pkg::ST_SETUP;
                    nxt_ff.cnt = '0;
                    nxt_ff.pins.host_select_n = 1'b0;
                    nxt_ff.pins.register_data_select = req.is_data;
                    nxt_ff.pins.bus_out = req.wdata;
                    nxt_ff.pins.bus_oe = ~req.is_read;
                    // in 6800 mode the read strobe pin carries direction
                    if (mode_6800) begin
                        nxt_ff.pins.rd_strobe = req.is_read;
                    end else begin
                        nxt_ff.pins.rd_strobe = 1'b1;
                    end
                end
            end

            lcd_host_pkg::ST_SETUP: begin
                // select, address and data settle before any strobe moves
                if (cnt_done) begin
                    nxt_ff.cnt = '0;
                    nxt_ff.phase = lcd_host_pkg::ST_ACTIVE;
                    if (cur_ff.mode_6800) begin
                        nxt_ff.pins.wr_strobe = 1'b1;
                    end else if (cur_ff.req.is_read) begin
                        nxt_ff.pins.rd_strobe = 1'b0;
                    end else begin
                        nxt_ff.pins.wr_strobe = 1'b0;
                    end
                end else begin
                    nxt_ff.cnt = cur_ff.cnt + 16'h0001;
                end
            end

            lcd_host_pkg::ST_ACTIVE: begin
                // address, direction and data held unchanged here
                if (cnt_done) begin
                    nxt_ff.cnt = '0;
                    nxt_ff.phase = lcd_host_pkg::ST_HOLD;
                    // extra active cycles let the synchroniser catch up; writes leave the last read alone
                    if (cur_ff.req.is_read) begin
                        nxt_ff.rdata = cur_ff.sync2;
                    end
                    if (cur_ff.mode_6800) begin
                        nxt_ff.pins.wr_strobe = 1'b0;
                    end else begin
                        nxt_ff.pins.wr_strobe = 1'b1;
                        nxt_ff.pins.rd_strobe = 1'b1;
                    end
                end else begin
                    nxt_ff.cnt = cur_ff.cnt + 16'h0001;
                end
            end

            lcd_host_pkg::ST_HOLD: begin
                // data and select outlast the strobe edge that the display latches on
                if (cnt_done) begin
                    nxt_ff.cnt = '0;
                    nxt_ff.phase = lcd_host_pkg::ST_RECOVER;
                    nxt_ff.pins.host_select_n = 1'b1;
                    nxt_ff.pins.bus_oe = 1'b0;
                    nxt_ff.pins.rd_strobe = 1'b1;
                end else begin
                    nxt_ff.cnt = cur_ff.cnt + 16'h0001;
                end
            end

            lcd_host_pkg::ST_RECOVER: begin
                // keeps the enable low long enough before the next cycle
                if (cnt_done) begin
                    nxt_ff.cnt = '0;
                    nxt_ff.phase = lcd_host_pkg::ST_IDLE;
                    nxt_ff.ready = 1'b1;
                    nxt_ff.rvalid = cur_ff.req.is_read;
                end else begin
                    nxt_ff.cnt = cur_ff.cnt + 16'h0001;
                end
            end

            default: begin
                // an unreachable phase falls back to idle with a fresh counter
                nxt_ff.phase = lcd_host_pkg::ST_IDLE;
                nxt_ff.cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur_ff <= RESET_IMAGE;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // every output is a field of the state register, no logic after the flops
    assign req_ready = cur_ff.ready;
    assign rd_valid = cur_ff.rvalid;
    assign rd_data = cur_ff.rdata;
    assign pins = cur_ff.pins;
endmodule : lcd_parallel_host_port

// ### shared/lcd_host_pkg.sv
// package for the parallel host port controller of a display controller
// assumes a 50 MHz system clock; the display latches on strobe edges
package lcd_host_pkg;
    localparam int DATA_W = 18;
    localparam int CLK_NS = 20;
    // strobe timing, ns as printed for the enable phases and setup
    localparam int SETUP_NS = 50;
    localparam int PW_LOW_NS = 33;
    localparam int PW_HIGH_NS = 66;
    localparam int HOLD_NS = 50;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PW_LOW_CYC = (PW_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int PW_HIGH_CYC = (PW_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    // the read synchroniser needs two extra active cycles before data is taken
    localparam int SYNC_CYC = 2;
    localparam int ACTIVE_CYC = PW_HIGH_CYC + SYNC_CYC;
    // reset pulse to the display, ns
    localparam int RESET_NS = 10000;
    localparam int RESET_CYC = RESET_NS / CLK_NS;
    localparam int CNT_W = 16;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_IDLE,
        ST_SETUP,
        ST_ACTIVE,
        ST_RECOVER,
        ST_HOLD
    } phase_t;

    typedef struct packed {
        logic              is_read;
        logic              is_data;
        logic [DATA_W-1:0] wdata;
    } request_t;

    typedef struct packed {
        logic              host_select_n;
        logic              register_data_select;
        logic              wr_strobe;
        logic              rd_strobe;
        logic              reset_n;
        logic              colour_depth_select;
        logic [DATA_W-1:0] bus_out;
        logic              bus_oe;
    } pins_t;

    typedef struct packed {
        phase_t            phase;
        logic [CNT_W-1:0]  cnt;
        request_t          req;
        logic              mode_6800;
        pins_t             pins;
        logic              ready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] sync1;
        logic [DATA_W-1:0] sync2;
    } state_t;
endpackage : lcd_host_pkg

// ### tb/lcd_port_props.sv
// assertions on the parallel host port controller
// assumes binding to the controller's top module
`timescale 1ns/1ns
module lcd_port_props #(
    parameter int RESET_CYCLES = 4
) (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   rst,
    // configuration and request side
    input wire logic                   mode_6800,
    input wire logic                   colour_262k,
    input wire logic                   req_valid,
    input wire lcd_host_pkg::request_t req,
    input wire logic                   req_ready,
    input wire logic                   rd_valid,
    // display pins
    input wire lcd_host_pkg::pins_t    pins
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire take = req_valid && req_ready;
    // the strobe stands six cycles: active phase plus the synchroniser margin
    sequence s_lo6(s); !s [*6] ##1 s; endsequence
    sequence s_hi6(s); s [*6] ##1 !s; endsequence
    a_idle_deselect: assert property (req_ready |-> pins.host_select_n)
        else $error("select low while idle");
    a_write_setup: assert property (take && !req.is_read |=> !pins.host_select_n && pins.bus_oe &&
        pins.bus_out == $past(req.wdata) && pins.register_data_select == $past(req.is_data))
        else $error("write setup wrong");
    a_read_release: assert property (take && req.is_read |=> !pins.bus_oe && !pins.host_select_n)
        else $error("host drives bus on read");
    a_wr_pulse: assert property (take && !mode_6800 && !req.is_read |-> ##4 s_lo6(pins.wr_strobe))
        else $error("write strobe pulse wrong");
    a_en_pulse: assert property (take && mode_6800 |-> ##4 s_hi6(pins.wr_strobe))
        else $error("enable pulse wrong");
    a_direction_set: assert property (take && mode_6800 |=> pins.rd_strobe == $past(req.is_read))
        else $error("direction wrong");
    a_hold_stable: assert property (pins.bus_oe && !pins.host_select_n && !$past(pins.host_select_n)
        |-> $stable(pins.bus_out) && $stable(pins.register_data_select)) else $error("bus moved mid access");
    a_reset_busy: assert property (!pins.reset_n |-> !req_ready)
        else $error("ready during display reset");
    a_depth_copy: assert property (1'b1 |=> pins.colour_depth_select == $past(colour_262k))
        else $error("depth select not copied");
    a_read_answer: assert property (take && req.is_read |-> ##[2:20] rd_valid)
        else $error("read not answered");
endmodule : lcd_port_props
bind lcd_parallel_host_port lcd_port_props #(.RESET_CYCLES(RESET_CYCLES)) u_props (.clk(clk), .rst(rst),
    .mode_6800(mode_6800), .colour_262k(colour_262k), .req_valid(req_valid), .req_ready(req_ready),
    .rd_valid(rd_valid), .req(req), .pins(pins));

// ### tb/lcd_panel_model.sv
// behavioural display controller port: one register word and one data word
// assumes the bench tells it which strobe convention is wired
`timescale 1ns/1ns
module lcd_panel_model (
    // strobe convention and pins from the host
    input  wire logic                       m68,
    input  wire lcd_host_pkg::pins_t        p,
    // data and colour depth seen at the display
    output logic [lcd_host_pkg::DATA_W-1:0] bus_in,
    output logic                            depth_262k
);
    logic [lcd_host_pkg::DATA_W-1:0] store [2];
    logic rd;
    always @(posedge p.wr_strobe or negedge p.reset_n) begin
        if (!p.reset_n) begin
            store[0] <= '0;
            store[1] <= '0;
        end else if (!p.host_select_n && !(m68 && p.rd_strobe)) begin
            store[p.register_data_select] <= p.bus_out;
        end
    end
    always_comb begin
        rd = !p.host_select_n && (m68 ? (p.rd_strobe && p.wr_strobe) : !p.rd_strobe);
        // released bus shows the inverse so stale data cannot pass
        bus_in = rd ? store[p.register_data_select] : ~store[p.register_data_select];
        depth_262k = p.colour_depth_select;
    end
endmodule : lcd_panel_model

// ### tb/lcd_parallel_host_port_tb_top.sv
// bench for the parallel host port controller
// assumes the panel model stands on the display pins
`timescale 1ns/1ns
module lcd_parallel_host_port_tb_top;
    logic clk, rst, mode_6800, colour_262k, soft_reset, req_valid, req_ready, rd_valid, depth_262k;
    lcd_host_pkg::request_t req;
    lcd_host_pkg::pins_t pins;
    logic [17:0] rd_data, bus_in;
    int err_count = 0, checks_done = 0;
    lcd_parallel_host_port #(.RESET_CYCLES(4)) dut (.clk(clk), .rst(rst), .mode_6800(mode_6800),
        .colour_262k(colour_262k), .soft_reset(soft_reset), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins), .bus_in(bus_in));
    lcd_panel_model panel (.m68(mode_6800), .p(pins), .bus_in(bus_in), .depth_262k(depth_262k));
    task automatic check(input logic [19:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic wait_ready;
        int n = 0;
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check(req_ready, 1'b1);
    endtask : wait_ready
    task automatic xfer(input logic r, d, input logic [17:0] w, output logic [17:0] q);
        int n = 0;
        wait_ready();
        req = '{r, d, w};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        while (r && rd_valid !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (r) begin
            check(rd_valid, 1'b1);
        end
        q = rd_data;
        wait_ready();
    endtask : xfer
    task automatic t_reset;
        rst = 1'b0;
        wait_ready();
        check(pins.host_select_n, 1'b1);
    endtask : t_reset
    task automatic t_rw(input logic m);
        logic [17:0] q;
        mode_6800 = m;
        // register then data word back to back, distinct per mode
        xfer(1'b0, 1'b0, m ? 18'h0c3a1 : 18'h002a5, q);
        xfer(1'b0, 1'b1, m ? 18'h2f00e : 18'h15a3c, q);
        xfer(1'b1, 1'b0, 18'h0, q);
        check(q, m ? 18'h0c3a1 : 18'h002a5);
        xfer(1'b1, 1'b1, 18'h0, q);
        check(q, m ? 18'h2f00e : 18'h15a3c);
    endtask : t_rw
    task automatic t_soft;
        logic [17:0] q;
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
        @(negedge clk);
        xfer(1'b1, 1'b0, 18'h0, q);
        check(q, 18'h0);
    endtask : t_soft
    task automatic t_depth;
        for (int v = 1; v >= 0; v--) begin
            colour_262k = v[0];
            repeat (2) @(negedge clk);
            check(depth_262k, v[0]);
        end
    endtask : t_depth
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200000;
        err_count++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        mode_6800 = 1'b0;
        colour_262k = 1'b0;
        soft_reset = 1'b0;
        req_valid = 1'b0;
        req = '0;
        repeat (20) @(negedge clk);
        t_reset();
        t_rw(1'b0);
        t_rw(1'b1);
        t_soft();
        t_depth();
        conclude();
    end
endmodule : lcd_parallel_host_port_tb_top
